// ### hw/clkgen_pkg.sv
// Constants and types shared by the clock generator control block.
// Assumes a single 20 MHz clock with a synchronous active-high reset.
package clkgen_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_KHZ      = 20000;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned HS_OSC_KHZ   = 8000;
	localparam int unsigned SLOW_OSC_KHZ = 240;
	localparam int unsigned HS_DIV       = CLK_KHZ / HS_OSC_KHZ;
	localparam int unsigned SLOW_DIV     = CLK_KHZ / SLOW_OSC_KHZ;
	localparam int unsigned OP_STOP_NS   = 544000;
	localparam int unsigned HOLD_CYC     = (OP_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_W       = 20;
	localparam int unsigned STAB_W       = 18;
	localparam int unsigned STAB_CYC_0   = 1024;
	localparam int unsigned STAB_CYC_1   = 4096;
	localparam int unsigned STAB_CYC_2   = 32768;
	localparam int unsigned STAB_CYC_3   = 131072;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] OFS_DIV    = 5'h00;
	localparam logic [4:0] OFS_SLOW   = 5'h04;
	localparam logic [4:0] OFS_WAIT   = 5'h08;
	localparam logic [4:0] OFS_WDT    = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;

	localparam logic [1:0] DIV_RST  = 2'h0;
	localparam logic [1:0] DIV_BAD  = 2'h3;
	localparam logic       SLOW_RST = 1'h0;
	localparam logic [1:0] WAIT_RST = 2'h0;
	localparam logic [1:0] WDT_RST  = 2'h2;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_INT = 2'h0,
		SRC_RES = 2'h1,
		SRC_EXT = 2'h2
	} src_t;

	typedef enum logic [1:0] {
		WDT_OFF  = 2'h0,
		WDT_SYS  = 2'h1,
		WDT_SLOW = 2'h2
	} wdt_src_t;

	typedef enum logic [5:0] {
		ST_OPT  = 6'h01,
		ST_HOLD = 6'h02,
		ST_STAB = 6'h04,
		ST_RUN  = 6'h08,
		ST_STOP = 6'h10,
		ST_WAKE = 6'h20
	} seq_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] spare;
		logic [1:0] stab_sel;
		logic       stoppable;
		logic [1:0] src;
	} opt_t;

	typedef struct packed {
		logic sys;
		logic cpu;
		logic periph;
		logic slow;
		logic wdt;
		logic tmr;
	} clk_en_t;

endpackage

// ### hw/clock_generator_control.sv
// Clock generator control: source select, start-up hold, stabilisation,
// peripheral divider and slow oscillator gating, behind an Avalon-MM slave.
// Assumes all inputs are synchronous to clk; oscillators appear as enables.
//
// Contract
// - System clock comes from one source picked by the config byte.
// - Internal fast source starts the CPU with no stabilisation wait.
// - Internal fast source frees both oscillator pins for port use.
// - CPU stays halted for the operation stop interval after power-on reset.
// - After reset release, config byte is read, then the source is selected.
// - Resonator: run internal clock first, switch after the byte's wait.
// - STOP release uses the wait register, not the config byte wait.
// - External clock source frees the second oscillator pin for port use.
// - Peripheral clock is system clock divided by 1, 2 or 4; 11 forbidden.
// - Slow oscillator starts running as soon as reset is released.
// - If stoppable, stop bit 0 runs and 1 stops the slow oscillator.
// - If not stoppable, slow oscillator runs and watchdog uses it.
// - Slow oscillator runs independently of the CPU clock.
// - Timer on the slow clock keeps counting in standby.
// - Watchdog gating follows stop bit and CPU state; timer gating follows the stop bit only.
// - Watchdog clock is system clock, slow clock, or stopped.
// - Reset clears the slow oscillator mode register.
// - STOP-release wait is 2^10, 2^12, 2^15 or 2^17 system clocks.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module clock_generator_control #(
	parameter int unsigned HOLD_CYCLES = clkgen_pkg::HOLD_CYC,
	parameter int unsigned STAB_CNT_0  = clkgen_pkg::STAB_CYC_0,
	parameter int unsigned STAB_CNT_1  = clkgen_pkg::STAB_CYC_1,
	parameter int unsigned STAB_CNT_2  = clkgen_pkg::STAB_CYC_2,
	parameter int unsigned STAB_CNT_3  = clkgen_pkg::STAB_CYC_3
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	// Configuration byte and oscillator pin
	input  wire clkgen_pkg::opt_t    opt_byte,
	input  wire logic                osc_pin_in,
	// CPU state
	input  wire logic                standby,
	input  wire logic                stop_req,
	input  wire logic                wake,
	// Avalon-MM slave
	input  wire logic [4:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	output logic [31:0]              readdata,
	output logic                     waitrequest,
	// Clock enables and status
	output clkgen_pkg::clk_en_t      clk_en,
	output logic                     cpu_run,
	output logic                     osc_in_gpio,
	output logic                     osc_out_gpio,
	output logic                     osc_amp_en
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	clkgen_pkg::seq_t state_r;
	clkgen_pkg::opt_t opt_r;
	logic [clkgen_pkg::HOLD_W-1:0] hold_cnt_r;
	logic [clkgen_pkg::STAB_W-1:0] stab_cnt_r;
	logic [1:0] peripheral_divider_reg;
	logic       slow_osc_stop_bit;
	logic [1:0] stop_release_wait_reg;
	logic [1:0] wdt_src_r;
	logic [1:0] div_act_r;
	logic [1:0] div_cnt_r;
	logic       pin_prev_r;
	logic       pin_edge;
	logic       hs_tick;
	logic       slow_tick;
	logic       slow_run;
	logic       sys_tick;
	logic       sys_live;
	logic       in_standby;
	logic       is_res;
	logic       wdt_tick;
	logic       periph_tick;
	logic [1:0] wdt_eff;
	logic       bus_go;

	localparam logic [clkgen_pkg::HOLD_W-1:0] HOLD_LAST =
		clkgen_pkg::HOLD_W'(HOLD_CYCLES - 1);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [clkgen_pkg::STAB_W-1:0] stab_last(input logic [1:0] sel);
		case (sel)
			2'h0:    stab_last = clkgen_pkg::STAB_W'(STAB_CNT_0 - 1);
			2'h1:    stab_last = clkgen_pkg::STAB_W'(STAB_CNT_1 - 1);
			2'h2:    stab_last = clkgen_pkg::STAB_W'(STAB_CNT_2 - 1);
			default: stab_last = clkgen_pkg::STAB_W'(STAB_CNT_3 - 1);
		endcase
	endfunction

	function automatic logic [1:0] div_last(input logic [1:0] sel);
		case (sel)
			2'h1:    div_last = 2'h1;
			2'h2:    div_last = 2'h3;
			default: div_last = 2'h0;
		endcase
	endfunction

	// ----------------------------------------
	// Oscillator ticks
	// ----------------------------------------
	tick_gen #(
		.DIV (clkgen_pkg::HS_DIV)
	) u_hs_osc (
		.clk  (clk),
		.srst (srst),
		.en   (state_r != clkgen_pkg::ST_STOP),
		.tick (hs_tick)
	);

	// Runs regardless of CPU clock state
	tick_gen #(
		.DIV (clkgen_pkg::SLOW_DIV)
	) u_slow_osc (
		.clk  (clk),
		.srst (srst),
		.en   (slow_run),
		.tick (slow_tick)
	);

	always_ff @(posedge clk) begin
		if (srst)
			pin_prev_r <= 1'b0;
		else
			pin_prev_r <= osc_pin_in;
	end

	assign pin_edge = osc_pin_in && !pin_prev_r;
	assign is_res   = opt_r.src == clkgen_pkg::SRC_RES;

	// Stop bit only honoured when the config byte allows it
	assign slow_run = !(opt_r.stoppable && slow_osc_stop_bit);

	// ----------------------------------------
	// System clock source
	// ----------------------------------------
	always_comb begin
		sys_live = (state_r == clkgen_pkg::ST_HOLD) || (state_r == clkgen_pkg::ST_STAB) ||
			(state_r == clkgen_pkg::ST_RUN);
		if (state_r != clkgen_pkg::ST_RUN || opt_r.src == clkgen_pkg::SRC_INT ||
			opt_r.src == 2'h3)
			sys_tick = sys_live && hs_tick;
		else
			sys_tick = pin_edge;
	end

	// ----------------------------------------
	// Start-up and STOP sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r    <= clkgen_pkg::ST_OPT;
			hold_cnt_r <= '0;
			stab_cnt_r <= '0;
		end else begin
			case (state_r)
				clkgen_pkg::ST_OPT: begin
					state_r    <= clkgen_pkg::ST_HOLD;
					hold_cnt_r <= '0;
				end
				clkgen_pkg::ST_HOLD: begin
					if (hold_cnt_r == HOLD_LAST) begin
						stab_cnt_r <= '0;
						if (is_res)
							state_r <= clkgen_pkg::ST_STAB;
						else
							state_r <= clkgen_pkg::ST_RUN;
					end else begin
						hold_cnt_r <= hold_cnt_r + 1'b1;
					end
				end
				clkgen_pkg::ST_STAB: begin
					if (pin_edge) begin
						if (stab_cnt_r == stab_last(opt_r.stab_sel))
							state_r <= clkgen_pkg::ST_RUN;
						else
							stab_cnt_r <= stab_cnt_r + 1'b1;
					end
				end
				clkgen_pkg::ST_RUN: begin
					if (stop_req)
						state_r <= clkgen_pkg::ST_STOP;
				end
				clkgen_pkg::ST_STOP: begin
					stab_cnt_r <= '0;
					if (wake) begin
						if (is_res)
							state_r <= clkgen_pkg::ST_WAKE;
						else
							state_r <= clkgen_pkg::ST_RUN;
					end
				end
				clkgen_pkg::ST_WAKE: begin
					if (pin_edge) begin
						if (stab_cnt_r == stab_last(stop_release_wait_reg))
							state_r <= clkgen_pkg::ST_RUN;
						else
							stab_cnt_r <= stab_cnt_r + 1'b1;
					end
				end
				default: state_r <= clkgen_pkg::ST_OPT;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration byte capture
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst)
			opt_r <= '0;
		else if (state_r == clkgen_pkg::ST_OPT)
			opt_r <= opt_byte;
	end

	// ----------------------------------------
	// Pin release and oscillator amplifier
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst || state_r == clkgen_pkg::ST_OPT) begin
			osc_in_gpio  <= 1'b0;
			osc_out_gpio <= 1'b0;
			osc_amp_en   <= 1'b0;
		end else begin
			osc_in_gpio  <= opt_r.src == clkgen_pkg::SRC_INT;
			osc_out_gpio <= !is_res;
			osc_amp_en   <= is_res;
		end
	end

	// ----------------------------------------
	// Peripheral divider
	// ----------------------------------------
	// New ratio is loaded only at the end of a full period
	always_ff @(posedge clk) begin
		if (srst) begin
			div_act_r   <= clkgen_pkg::DIV_RST;
			div_cnt_r   <= '0;
			periph_tick <= 1'b0;
		end else begin
			periph_tick <= 1'b0;
			if (sys_tick) begin
				if (div_cnt_r == div_last(div_act_r)) begin
					div_cnt_r   <= '0;
					periph_tick <= 1'b1;
					div_act_r   <= peripheral_divider_reg;
				end else begin
					div_cnt_r <= div_cnt_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Watchdog and timer gating
	// ----------------------------------------
	assign in_standby = standby || (state_r == clkgen_pkg::ST_STOP) ||
		(state_r == clkgen_pkg::ST_WAKE);
	assign wdt_eff = opt_r.stoppable ? wdt_src_r : clkgen_pkg::WDT_SLOW;

	always_comb begin
		case (wdt_eff)
			clkgen_pkg::WDT_SYS:  wdt_tick = sys_tick && !in_standby;
			clkgen_pkg::WDT_SLOW: wdt_tick = slow_tick && !(opt_r.stoppable && in_standby);
			default:              wdt_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			clk_en  <= '0;
			cpu_run <= 1'b0;
		end else begin
			clk_en.sys    <= sys_tick;
			clk_en.cpu    <= sys_tick && state_r == clkgen_pkg::ST_RUN;
			clk_en.periph <= periph_tick;
			clk_en.slow   <= slow_tick;
			clk_en.wdt    <= wdt_tick;
			clk_en.tmr    <= slow_tick;
			cpu_run       <= state_r == clkgen_pkg::ST_RUN;
		end
	end

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// Request seen with waitrequest high; answered one cycle later
	assign bus_go = (read || write) && !waitrequest;

	always_ff @(posedge clk) begin
		if (srst) begin
			waitrequest <= 1'b1;
			readdata    <= '0;
		end else if (bus_go) begin
			waitrequest <= 1'b1;
		end else if (read || write) begin
			waitrequest <= 1'b0;
			readdata    <= '0;
			if (read) begin
				case (address)
					clkgen_pkg::OFS_DIV:    readdata[1:0] <= peripheral_divider_reg;
					clkgen_pkg::OFS_SLOW:   readdata[0]   <= slow_osc_stop_bit;
					clkgen_pkg::OFS_WAIT:   readdata[1:0] <= stop_release_wait_reg;
					clkgen_pkg::OFS_WDT:    readdata[1:0] <= wdt_src_r;
					clkgen_pkg::OFS_STATUS: readdata[13:0] <= {div_act_r, state_r, slow_run,
						opt_r.stoppable, opt_r.stab_sel, opt_r.src};
					default:                readdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			peripheral_divider_reg <= clkgen_pkg::DIV_RST;
			slow_osc_stop_bit      <= clkgen_pkg::SLOW_RST;
			stop_release_wait_reg  <= clkgen_pkg::WAIT_RST;
			wdt_src_r              <= clkgen_pkg::WDT_RST;
		end else if (bus_go && write) begin
			case (address)
				clkgen_pkg::OFS_DIV: begin
					if (writedata[1:0] != clkgen_pkg::DIV_BAD)
						peripheral_divider_reg <= writedata[1:0];
				end
				clkgen_pkg::OFS_SLOW: slow_osc_stop_bit     <= writedata[0];
				clkgen_pkg::OFS_WAIT: stop_release_wait_reg <= writedata[1:0];
				clkgen_pkg::OFS_WDT:  wdt_src_r             <= writedata[1:0];
				default: ;
			endcase
		end
	end

endmodule // clock_generator_control
`default_nettype wire

// ### hw/tick_gen.sv
// Free-running divider that emits a one-cycle tick every DIV clocks.
// Assumes the enable is held low while the tick must not run.
`timescale 1ns/1ns
`default_nettype none
module tick_gen #(
	parameter int unsigned DIV = 2
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Control
	input  wire logic en,
	// Tick out
	output logic      tick
);
	localparam int unsigned W = $clog2(DIV + 1);
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (srst || !en) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // tick_gen
`default_nettype wire

// ### verification/clkgen_assertions.sv
// Concurrent checks on the clock generator control ports.
// Assumes opt_byte changes only while srst is high.
`timescale 1ns/1ns
`default_nettype none
module clkgen_checker #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                srst,
	// Inputs
	input wire clkgen_pkg::opt_t    opt_byte,
	input wire logic                standby,
	input wire logic                read,
	input wire logic                write,
	// Outputs
	input wire logic                waitrequest,
	input wire clkgen_pkg::clk_en_t clk_en,
	input wire logic                cpu_run,
	input wire logic                osc_in_gpio,
	input wire logic                osc_out_gpio,
	input wire logic                osc_amp_en
);
	int unsigned up_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk) begin
		if (srst) begin
			up_r <= 0;
		end else if (up_r < 100000) begin
			up_r <= up_r + 1;
		end
	end
	sequence s_req;
		(read || write) && waitrequest;
	endsequence
	sequence s_ans;
		!waitrequest ##1 waitrequest;
	endsequence
	property p_one_wait;
		s_req |=> s_ans;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer not one cycle");
	property p_hold;
		$rose(cpu_run) |-> up_r >= HOLD_CYCLES;
	endproperty
	a_hold: assert property (p_hold) else $error("cpu started early");
	property p_fast;
		up_r == HOLD_CYCLES + 4 && opt_byte.src == clkgen_pkg::SRC_INT |-> cpu_run;
	endproperty
	a_fast: assert property (p_fast) else $error("internal start delayed");
	property p_int_pins;
		cpu_run && opt_byte.src == clkgen_pkg::SRC_INT |-> osc_in_gpio && osc_out_gpio && !osc_amp_en;
	endproperty
	a_int_pins: assert property (p_int_pins) else $error("pins kept on internal");
	property p_res_pins;
		cpu_run && opt_byte.src == clkgen_pkg::SRC_RES |-> osc_amp_en && !osc_in_gpio && !osc_out_gpio;
	endproperty
	a_res_pins: assert property (p_res_pins) else $error("resonator pins wrong");
	property p_ext_pins;
		cpu_run && opt_byte.src == clkgen_pkg::SRC_EXT |-> !osc_in_gpio && osc_out_gpio && !osc_amp_en;
	endproperty
	a_ext_pins: assert property (p_ext_pins) else $error("external pins wrong");
	property p_fixed_wdt;
		!opt_byte.stoppable && cpu_run |-> clk_en.wdt == clk_en.slow;
	endproperty
	a_fixed_wdt: assert property (p_fixed_wdt) else $error("watchdog not on slow clock");
	property p_tmr_slow;
		clk_en.tmr == clk_en.slow;
	endproperty
	a_tmr_slow: assert property (p_tmr_slow) else $error("timer not on slow clock");
	property p_stby_wdt;
		opt_byte.stoppable && standby && $past(standby) |-> !clk_en.wdt;
	endproperty
	a_stby_wdt: assert property (p_stby_wdt) else $error("watchdog ran in standby");
	property p_cpu_tick;
		clk_en.cpu |-> cpu_run || $past(cpu_run);
	endproperty
	a_cpu_tick: assert property (p_cpu_tick) else $error("cpu tick while halted");
endmodule // clkgen_checker
bind clock_generator_control clkgen_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_clkgen_checker (
	.clk(clk), .srst(srst), .opt_byte(opt_byte), .standby(standby), .read(read), .write(write),
	.waitrequest(waitrequest), .clk_en(clk_en), .cpu_run(cpu_run), .osc_in_gpio(osc_in_gpio),
	.osc_out_gpio(osc_out_gpio), .osc_amp_en(osc_amp_en));
`default_nettype wire

// ### verification/clock_generator_control_tb_top.sv
// Self-checking bench for the clock generator control block.
// Assumes the oscillator model on the pin and a 20 MHz bench clock.
`timescale 1ns/1ns
`default_nettype none
module clock_generator_control_tb_top;
	localparam int unsigned H = 20;
	localparam int unsigned P = 4;
	logic clk = 1'b0, srst = 1'b1, standby = 1'b0, stop_req = 1'b0, wake = 1'b0;
	logic read = 1'b0, write = 1'b0, waitrequest, cpu_run, in_g, out_g, amp, pin;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic [15:0] seed = 16'h23d5;
	clkgen_pkg::opt_t opt_byte = 8'h00;
	clkgen_pkg::clk_en_t clk_en;
	int miscompares = 0, n_checks = 0, t, gmin, k, lo;
	int c[6];
	always #25 clk = ~clk;
	osc_model #(.P(P)) u_osc_model (.clk(clk), .run(amp || opt_byte.src == clkgen_pkg::SRC_EXT), .pin(pin));
	clock_generator_control #(.HOLD_CYCLES(H), .STAB_CNT_0(4), .STAB_CNT_1(6), .STAB_CNT_2(8),
		.STAB_CNT_3(10)) u_clock_generator_control (.clk(clk), .srst(srst), .opt_byte(opt_byte),
		.osc_pin_in(pin), .standby(standby), .stop_req(stop_req), .wake(wake), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .clk_en(clk_en), .cpu_run(cpu_run), .osc_in_gpio(in_g),
		.osc_out_gpio(out_g), .osc_amp_en(amp));
	// ----
	// Helpers
	// ----
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic int stab(input int s);
		return 4 + 2 * s;
	endfunction
	task automatic complete_run;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic bad(input int got);
		miscompares++;
		$display("unexpected at %0t: got %0h", $time, got);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) bad(got);
	endtask
	task automatic rng(input int got, input int a, input int b);
		n_checks++;
		if (got < a || got > b) bad(got);
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		i = 0;
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clk);
			i++;
		end while (waitrequest !== 1'b0 && i < 50);
		if (i >= 50) begin
			bad(i);
			complete_run();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic count(input int n);
		int g;
		g = 1000;
		gmin = 1000;
		c = '{default: 0};
		repeat (n) begin
			@(posedge clk);
			g++;
			for (int b = 0; b < 6; b++) if (clk_en[b] === 1'b1) c[b]++;
			if (clk_en.periph === 1'b1) begin
				gmin = (g < gmin) ? g : gmin;
				g = 0;
			end
		end
	endtask
	task automatic wait_run;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (cpu_run !== 1'b1 && t < 5000);
		if (t >= 5000) begin
			bad(t);
			complete_run();
		end
	endtask
	task automatic boot(input logic [1:0] s, input logic [1:0] w, input logic stp);
		opt_byte <= {3'h0, w, stp, s};
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		wait_run();
	endtask
	task automatic stop_wake;
		stop_req <= 1'b1;
		@(posedge clk);
		stop_req <= 1'b0;
		count(20);
		chk(cpu_run, 1'b0);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		wait_run();
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		for (int s = 0; s < 3; s++) begin
			seed = lfsr(seed);
			boot(s[1:0], seed[1:0], 1'b1);
			lo = (s == 1) ? H + (stab(seed[1:0]) - 1) * P : H;
			rng(t, lo, lo + ((s == 1) ? 3 * P + 4 : 4));
			chk({in_g, out_g, amp}, (s == 0) ? 3'h6 : (s == 1) ? 3'h1 : 3'h2);
			count(400);
			rng(c[5], 400 / ((s == 0) ? 2 : P) - 2, 400 / ((s == 0) ? 2 : P) + 2);
		end
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 5'(4 * i + (i / 4) * 4), 32'h0);
			chk(q, (i == 3) ? 32'h2 : 32'h0);
		end
		seed = lfsr(seed);
		bus(1'b1, 5'h14, {16'h0, seed});
		bus(1'b0, 5'h14, 32'h0);
		chk(q, 32'h0);
		for (int d = 2; d >= 0; d--) begin
			bus(1'b1, 5'h00, 32'(d));
			count(400);
			rng(c[3], (100 >> d) - 2, (100 >> d) + 2);
			rng(gmin, P, 1000);
		end
		bus(1'b1, 5'h00, 32'h3);
		bus(1'b0, 5'h00, 32'h0);
		chk(q, 32'h0);
		count(830);
		rng(c[2], 9, 11);
		rng(c[1], 9, 11);
		bus(1'b1, 5'h04, 32'h1);
		count(8);
		count(830);
		chk(c[2] + c[1] + c[0], 32'h0);
		bus(1'b1, 5'h04, 32'h0);
		standby <= 1'b1;
		count(8);
		count(830);
		chk(c[1], 32'h0);
		rng(c[0], 9, 11);
		standby <= 1'b0;
		bus(1'b1, 5'h0c, 32'h1);
		count(400);
		rng(c[1], 98, 102);
		bus(1'b1, 5'h0c, 32'h0);
		count(400);
		chk(c[1], 32'h0);
		boot(2'h0, 2'h0, 1'b0);
		bus(1'b1, 5'h04, 32'h1);
		bus(1'b1, 5'h0c, 32'h1);
		standby <= 1'b1;
		count(830);
		rng(c[2], 9, 11);
		rng(c[1], 9, 11);
		standby <= 1'b0;
		stop_wake();
		rng(t, 1, 4);
		seed = lfsr(seed);
		boot(2'h1, 2'h0, 1'b1);
		k = 1 + seed % 3;
		bus(1'b1, 5'h08, 32'(k));
		stop_wake();
		rng(t, (stab(k) - 1) * P, stab(k) * P + 2 * P + 4);
		complete_run();
	end
endmodule // clock_generator_control_tb_top
`default_nettype wire

// ### verification/osc_model.sv
// Resonator or external clock source at the oscillator pin.
// Assumes run is high while the far side oscillates; pin rests low otherwise.
`timescale 1ns/1ns
`default_nettype none
module osc_model #(
	parameter int unsigned P = 4
) (
	// Clock and control
	input  wire logic clk,
	input  wire logic run,
	// Pin
	output logic      pin
);
	int unsigned n;
	initial begin
		n = 0;
		pin = 1'b0;
	end
	// Square wave of P bench clocks
	always @(posedge clk) begin
		n <= (n + 1) % P;
		pin <= run && (n < P / 2);
	end
endmodule // osc_model
`default_nettype wire
